// ---- common/can_xcvr_regs.svh ----
// Timing counts and mode field codes of the CAN transceiver mode logic
`ifndef CAN_XCVR_REGS_SVH
`define CAN_XCVR_REGS_SVH

`define CLK_PERIOD_NS 8
// Mode control field codes
`define MODE_FLD_OFF 2'h0
`define MODE_FLD_WAKE 2'h1
`define MODE_FLD_RXO 2'h2
`define MODE_FLD_NORM 2'h3
// Enabling delay, least time, rounded up
`define CAN_EN_NS 10000
`define CAN_EN_CYC ((`CAN_EN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Transmit time-out, least time, rounded up
`define TXD_TO_NS 2000000
`define TXD_TO_CYC ((`TXD_TO_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Wake phase window: least rounded up, longest rounded down
`define WAKE_MIN_PHASE_NS 1000
`define WAKE_MIN_CYC ((`WAKE_MIN_PHASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_MAX_PHASE_NS 4000
`define WAKE_MAX_CYC (`WAKE_MAX_PHASE_NS / `CLK_PERIOD_NS)
// Controller bit time in clock cycles
`define CTRL_BIT_DIV 125

`endif

// ---- common/can_xcvr_pkg.sv ----
// Types shared by both ends of the CAN transceiver link
package can_xcvr_pkg;
   typedef enum logic [2:0] {
      PM_NORMAL = 3'h0,
      PM_STOP = 3'h1,
      PM_SLEEP = 3'h2,
      PM_RESTART = 3'h3,
      PM_FAILSAFE = 3'h4,
      PM_INIT = 3'h5
   } power_mode_t;

   typedef enum logic [3:0] {
      XM_OFF = 4'h1,
      XM_WAKE = 4'h2,
      XM_RXO = 4'h4,
      XM_NORM = 4'h8
   } xcvr_mode_t;

   typedef enum logic [3:0] {
      WK_IDLE = 4'h1,
      WK_DOM1 = 4'h2,
      WK_REC = 4'h4,
      WK_DOM2 = 4'h8
   } wake_state_t;

   typedef enum logic [1:0] {
      SER_IDLE = 2'h1,
      SER_SHIFT = 2'h2
   } ser_state_t;
endpackage

// ---- common/can_link_if.sv ----
// Logic-level link between CAN controller and transceiver
`timescale 1ns/1ps
interface can_link_if;
   logic transmit_data_input;
   logic receive_data;
   modport dev (input transmit_data_input, output receive_data);
   modport ctrl (output transmit_data_input, input receive_data);
endinterface

// ---- logic/can_ctrl_end.sv ----
// Controller end: transmit FIFO, bit serializer and receive sampler
`timescale 1ns/1ps
`include "can_xcvr_regs.svh"

module can_word_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
)(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wr_r, wr_nxt, rd_r, rd_nxt;
   logic push, pop;

   assign in_ready_o = (wr_r - rd_r) != (AW+1)'(DEPTH);
   assign out_valid_o = wr_r != rd_r;
   assign out_data_o = mem_r[rd_r[AW-1:0]];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_comb begin
      wr_nxt = wr_r;
      rd_nxt = rd_r;
      if (push) begin
         wr_nxt = wr_r + (AW+1)'(1);
      end
      if (pop) begin
         rd_nxt = rd_r + (AW+1)'(1);
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_r <= '0;
         rd_r <= '0;
      end else begin
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
      end
   end

   // Storage needs no reset; only pointers define content
   always_ff @(posedge ref_clk_i) begin
      if (push) begin
         mem_r[wr_r[AW-1:0]] <= in_data_i;
      end
   end
endmodule // can_word_fifo

module can_ctrl_end
   import can_xcvr_pkg::*;
#(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16,
   parameter int unsigned BIT_DIV = `CTRL_BIT_DIV,
   parameter int unsigned EN_CYC = `CAN_EN_CYC
)(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   can_link_if.ctrl link,
   input wire logic normal_req_i,
   input wire logic tx_valid_i,
   output logic tx_ready_o,
   input wire logic [WIDTH-1:0] tx_data_i,
   output logic tx_enabled_o,
   output logic rx_bit_o,
   output logic rx_valid_o
);
   localparam int unsigned DW = $clog2(BIT_DIV + 1);
   localparam int unsigned EW = $clog2(EN_CYC + 1);
   localparam int unsigned BW = $clog2(WIDTH + 1);

   ser_state_t st_r, st_nxt;
   logic [DW-1:0] div_r, div_nxt;
   logic [EW-1:0] en_r, en_nxt;
   logic [WIDTH-1:0] sh_r, sh_nxt;
   logic [BW-1:0] left_r, left_nxt;
   logic txd_r, txd_nxt;
   logic rxb_r, rxb_nxt, rxv_r, rxv_nxt;
   logic bit_en, enabled, f_valid, f_ready;
   logic [WIDTH-1:0] f_data;

   can_word_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(tx_valid_i),
      .in_ready_o(tx_ready_o),
      .in_data_i(tx_data_i),
      .out_valid_o(f_valid),
      .out_ready_i(f_ready),
      .out_data_o(f_data)
   );

   assign bit_en = div_r == '0;
   assign enabled = en_r == '0;
   // Serializer stalls until enabled, so FIFO fills
   assign f_ready = (st_r == SER_IDLE) && bit_en && enabled;
   assign link.transmit_data_input = txd_r;
   assign tx_enabled_o = enabled;
   assign rx_bit_o = rxb_r;
   assign rx_valid_o = rxv_r;

   always_comb begin
      div_nxt = bit_en ? DW'(BIT_DIV - 1) : div_r - DW'(1);
      en_nxt = enabled ? en_r : en_r - EW'(1);
      st_nxt = st_r;
      sh_nxt = sh_r;
      left_nxt = left_r;
      txd_nxt = txd_r;
      rxb_nxt = bit_en ? link.receive_data : rxb_r;
      rxv_nxt = bit_en;
      if (normal_req_i) begin
         // Abort any word and hold recessive through the delay
         en_nxt = EW'(EN_CYC);
         st_nxt = SER_IDLE;
         txd_nxt = 1'b1;
      end else if (bit_en) begin
         unique case (st_r)
            SER_IDLE: begin
               txd_nxt = 1'b1;
               if (f_valid && enabled) begin
                  txd_nxt = f_data[WIDTH-1];
                  sh_nxt = f_data << 1;
                  left_nxt = BW'(WIDTH - 1);
                  st_nxt = SER_SHIFT;
               end
            end
            SER_SHIFT: begin
               if (left_r == '0) begin
                  txd_nxt = 1'b1;
                  st_nxt = SER_IDLE;
               end else begin
                  txd_nxt = sh_r[WIDTH-1];
                  sh_nxt = sh_r << 1;
                  left_nxt = left_r - BW'(1);
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r <= SER_IDLE;
         div_r <= '0;
         en_r <= '0;
         sh_r <= '0;
         left_r <= '0;
         txd_r <= 1'b1;
         rxb_r <= 1'b1;
         rxv_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         div_r <= div_nxt;
         en_r <= en_nxt;
         sh_r <= sh_nxt;
         left_r <= left_nxt;
         txd_r <= txd_nxt;
         rxb_r <= rxb_nxt;
         rxv_r <= rxv_nxt;
      end
   end
endmodule // can_ctrl_end

// ---- logic/can_xcvr_dev.sv ----
// Transceiver end: mode control, enabling, time-out and wake detection
//
// Behaviour
// - Off after reset, selectable in every power mode except fail-safe
// - Off mode ignores bus wake activity
// - Off mode leaves bus pins undriven
// - Software mode writes select the transceiver mode
// - Normal mode enabled by write in normal power
// - Normal mode only in normal or stop power
// - Normal mode: low input drives dominant bus
// - Controller holds input high during enabling delay
// - Early low input returned high until delay ends
// - Low held through delay never transmitted
// - Receive output shows bus in normal and receive-only modes, low is dominant
// - Receive-only disables driver, keeps reception
// - Receive-only only in normal or stop power
// - Wake mode in stop/sleep/restart/normal, monitors bus
// - Fail-safe power forces wake-capable mode
// - Valid wake pattern raises wake event
// - Pattern dominant-recessive-dominant, phases within window
// - Wake holds receive low until mode changes
// - After wake, normal mode write takes effect
// - Mode field keeps reading 01 after wake
// - Re-arm by mode toggle or stop/fail-safe entry
// - Dominant time-out disables driver, sets failure
`timescale 1ns/1ps
`include "can_xcvr_regs.svh"

module can_xcvr_dev
   import can_xcvr_pkg::*;
#(
   parameter int unsigned EN_CYC = `CAN_EN_CYC,
   parameter int unsigned TXD_TO_CYC = `TXD_TO_CYC,
   parameter int unsigned WAKE_MIN_CYC = `WAKE_MIN_CYC,
   parameter int unsigned WAKE_MAX_CYC = `WAKE_MAX_CYC
)(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   can_link_if.dev link,
   input wire power_mode_t power_mode_i,
   input wire logic mode_wr_i,
   input wire logic [1:0] mode_wdata_i,
   output logic [1:0] mode_rdata_o,
   input wire logic bus_dom_i,
   output logic bus_drv_o,
   output logic bus_oe_o,
   output logic bus_bias_o,
   output logic wake_o,
   output logic fail_o,
   input wire logic fail_clr_i
);
   localparam int unsigned EW = $clog2(EN_CYC + 1);
   localparam int unsigned TW = $clog2(TXD_TO_CYC + 1);
   localparam int unsigned WW = $clog2(WAKE_MAX_CYC + 2);

   function automatic xcvr_mode_t fld_to_mode(input logic [1:0] f);
      unique case (f)
         `MODE_FLD_OFF: fld_to_mode = XM_OFF;
         `MODE_FLD_WAKE: fld_to_mode = XM_WAKE;
         `MODE_FLD_RXO: fld_to_mode = XM_RXO;
         default: fld_to_mode = XM_NORM;
      endcase
   endfunction

   function automatic logic [1:0] mode_to_fld(input xcvr_mode_t m);
      unique case (m)
         XM_OFF: mode_to_fld = `MODE_FLD_OFF;
         XM_WAKE: mode_to_fld = `MODE_FLD_WAKE;
         XM_RXO: mode_to_fld = `MODE_FLD_RXO;
         default: mode_to_fld = `MODE_FLD_NORM;
      endcase
   endfunction

   function automatic logic active_pm(input power_mode_t p);
      active_pm = (p == PM_NORMAL) || (p == PM_STOP);
   endfunction

   function automatic logic mode_ok(input xcvr_mode_t m,
                                    input power_mode_t p);
      unique case (m)
         XM_OFF: mode_ok = 1'b1;
         XM_WAKE: mode_ok = (p != PM_INIT);
         XM_RXO: mode_ok = active_pm(p);
         default: mode_ok = (p == PM_NORMAL) || active_pm(p);
      endcase
   endfunction

   function automatic logic in_window(input logic [WW-1:0] c);
      in_window = (c >= WW'(WAKE_MIN_CYC)) && (c <= WW'(WAKE_MAX_CYC));
   endfunction

   xcvr_mode_t mode_r, mode_nxt;
   wake_state_t wk_r, wk_nxt;
   power_mode_t pm_r;
   logic [WW-1:0] wcnt_r, wcnt_nxt;
   logic [EW-1:0] en_r, en_nxt;
   logic [TW-1:0] to_r, to_nxt;
   logic bus_s1_r, bus_s2_r;
   logic armed_r, armed_nxt, woken_r, woken_nxt;
   logic txarm_r, txarm_nxt, tout_r, tout_nxt;
   logic fail_r, fail_nxt, wake_r, wake_nxt;
   logic rxd_r, rxd_nxt, drv_r, drv_nxt, oe_r, oe_nxt;
   logic bias_r, bias_nxt;
   logic txd, mode_chg, pm_rearm, wake_hit, drive_en, en_done;
   xcvr_mode_t req;

   assign txd = link.transmit_data_input;
   assign link.receive_data = rxd_r;
   assign mode_rdata_o = mode_to_fld(mode_r);
   assign bus_drv_o = drv_r;
   assign bus_oe_o = oe_r;
   assign bus_bias_o = bias_r;
   assign wake_o = wake_r;
   assign fail_o = fail_r;
   assign en_done = en_r == '0;

   // Bus receiver level comes from outside the clock domain
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bus_s1_r <= 1'b0;
         bus_s2_r <= 1'b0;
      end else begin
         bus_s1_r <= bus_dom_i;
         bus_s2_r <= bus_s1_r;
      end
   end

   // Mode selection and wake arming
   always_comb begin
      req = fld_to_mode(mode_wdata_i);
      mode_nxt = mode_r;
      if (power_mode_i == PM_FAILSAFE) begin
         mode_nxt = XM_WAKE;
      end else if (mode_wr_i && mode_ok(req, power_mode_i)) begin
         mode_nxt = req;
      end else if (!active_pm(power_mode_i) &&
                   (mode_r == XM_NORM || mode_r == XM_RXO)) begin
         // Leaving normal/stop power: keep wake capability
         mode_nxt = XM_WAKE;
      end
      mode_chg = mode_nxt != mode_r;
      pm_rearm = (power_mode_i != pm_r) &&
                 (power_mode_i == PM_STOP || power_mode_i == PM_FAILSAFE);
      armed_nxt = armed_r;
      woken_nxt = woken_r;
      if (mode_chg) begin
         // On a mode change, only entry into wake mode arms detection
         armed_nxt = (mode_nxt == XM_WAKE);
         woken_nxt = 1'b0;
      end else if (pm_rearm) begin
         armed_nxt = 1'b1;
      end
      if (wake_hit && !mode_chg) begin
         woken_nxt = 1'b1;
         armed_nxt = 1'b0;
      end
   end

   // Wake pattern detector
   always_comb begin
      wk_nxt = wk_r;
      wcnt_nxt = (wcnt_r > WW'(WAKE_MAX_CYC)) ? wcnt_r : wcnt_r + WW'(1);
      wake_hit = 1'b0;
      if (mode_r != XM_WAKE || !armed_r) begin
         wk_nxt = WK_IDLE;
         wcnt_nxt = '0;
      end else if (wk_r != WK_IDLE && wcnt_r > WW'(WAKE_MAX_CYC)) begin
         wk_nxt = WK_IDLE;
      end else begin
         unique case (wk_r)
            WK_IDLE: begin
               if (bus_s2_r) begin
                  wk_nxt = WK_DOM1;
                  wcnt_nxt = WW'(1);
               end
            end
            WK_DOM1: begin
               if (!bus_s2_r) begin
                  wk_nxt = in_window(wcnt_r) ? WK_REC : WK_IDLE;
                  wcnt_nxt = WW'(1);
               end
            end
            WK_REC: begin
               if (bus_s2_r) begin
                  // Bad gap: this dominant may open a new pattern
                  wk_nxt = in_window(wcnt_r) ? WK_DOM2 : WK_DOM1;
                  wcnt_nxt = WW'(1);
               end
            end
            WK_DOM2: begin
               if (!bus_s2_r) begin
                  wake_hit = in_window(wcnt_r);
                  wk_nxt = WK_IDLE;
                  wcnt_nxt = '0;
               end
            end
         endcase
      end
   end

   // Enabling sequence, transmit time-out, pins and flags
   always_comb begin
      en_nxt = en_done ? en_r : en_r - EW'(1);
      txarm_nxt = txarm_r;
      if (mode_chg && mode_nxt == XM_NORM) begin
         en_nxt = EW'(EN_CYC);
         txarm_nxt = 1'b0;
      end else if (en_done && txd) begin
         // Low held across the delay is dropped until a new edge
         txarm_nxt = 1'b1;
      end
      drive_en = (mode_r == XM_NORM) && active_pm(power_mode_i) &&
                 en_done && txarm_r && !tout_r;
      to_nxt = '0;
      tout_nxt = tout_r;
      if (txd) begin
         tout_nxt = 1'b0;
      end else if (drive_en) begin
         to_nxt = to_r + TW'(1);
         if (to_r + TW'(1) >= TW'(TXD_TO_CYC)) begin
            tout_nxt = 1'b1;
         end
      end
      fail_nxt = fail_r;
      if (fail_clr_i) begin
         fail_nxt = 1'b0;
      end
      if (tout_nxt && !tout_r) begin
         fail_nxt = 1'b1;
      end
      oe_nxt = drive_en;
      drv_nxt = drive_en && !txd;
      bias_nxt = (mode_r == XM_NORM) || (mode_r == XM_RXO);
      unique case (mode_r)
         XM_OFF: rxd_nxt = 1'b1;
         XM_WAKE: rxd_nxt = !woken_r;
         default: rxd_nxt = !bus_s2_r;
      endcase
      wake_nxt = wake_hit && !mode_chg;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_r <= XM_OFF;
         pm_r <= PM_INIT;
         wk_r <= WK_IDLE;
         wcnt_r <= '0;
         armed_r <= 1'b0;
         woken_r <= 1'b0;
         en_r <= '0;
         txarm_r <= 1'b0;
         to_r <= '0;
         tout_r <= 1'b0;
         fail_r <= 1'b0;
         wake_r <= 1'b0;
         rxd_r <= 1'b1;
         drv_r <= 1'b0;
         oe_r <= 1'b0;
         bias_r <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         pm_r <= power_mode_i;
         wk_r <= wk_nxt;
         wcnt_r <= wcnt_nxt;
         armed_r <= armed_nxt;
         woken_r <= woken_nxt;
         en_r <= en_nxt;
         txarm_r <= txarm_nxt;
         to_r <= to_nxt;
         tout_r <= tout_nxt;
         fail_r <= fail_nxt;
         wake_r <= wake_nxt;
         rxd_r <= rxd_nxt;
         drv_r <= drv_nxt;
         oe_r <= oe_nxt;
         bias_r <= bias_nxt;
      end
   end
endmodule // can_xcvr_dev

// ---- verification/can_link_checker.sv ----
// Concurrent checks on the transceiver end and the link it drives
`timescale 1ns/1ps
module can_link_checker
   import can_xcvr_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic transmit_data_input,
   input wire logic receive_data,
   input wire power_mode_t power_mode_i,
   input wire logic mode_wr_i,
   input wire logic [1:0] mode_wdata_i,
   input wire logic [1:0] mode_rdata_o,
   input wire logic bus_drv_o,
   input wire logic bus_oe_o,
   input wire logic wake_o,
   input wire logic fail_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   // Driver outputs trail the mode field by one cycle
   a_off_no_drive: assert property (
      mode_rdata_o == 2'h0 && $past(mode_rdata_o) == 2'h0 |-> !bus_oe_o)
      else $error("driver enabled in off mode");
   a_off_no_wake: assert property (
      mode_rdata_o == 2'h0 && $past(mode_rdata_o) == 2'h0 |-> !wake_o)
      else $error("wake raised in off mode");
   a_rxo_no_drive: assert property (
      mode_rdata_o == 2'h2 && $past(mode_rdata_o) == 2'h2 |-> !bus_oe_o)
      else $error("driver enabled in receive-only mode");
   a_drv_follow_txd: assert property (
      bus_oe_o |-> bus_drv_o == !$past(transmit_data_input))
      else $error("bus driver does not follow transmit input");
   a_off_write_taken: assert property (
      mode_wr_i && mode_wdata_i == 2'h0 && power_mode_i != PM_FAILSAFE
      |=> mode_rdata_o == 2'h0)
      else $error("off mode write not applied");
   a_norm_write_taken: assert property (
      mode_wr_i && mode_wdata_i == 2'h3 && power_mode_i == PM_NORMAL
      |=> mode_rdata_o == 2'h3)
      else $error("normal mode write not applied");
   a_active_refused: assert property (
      mode_wr_i && mode_wdata_i[1] && !mode_rdata_o[1]
      && !(power_mode_i inside {PM_NORMAL, PM_STOP}) |=> !mode_rdata_o[1])
      else $error("active mode taken in wrong power mode");
   a_failsafe_forces: assert property (
      power_mode_i == PM_FAILSAFE [*3] |-> mode_rdata_o == 2'h1)
      else $error("fail-safe power did not force wake mode");
   a_wake_rxd_low: assert property (
      wake_o |-> ##[1:2] !receive_data)
      else $error("receive output not low after wake");
   a_wake_rxd_hold: assert property (
      !receive_data && mode_rdata_o == 2'h1 && $past(mode_rdata_o) == 2'h1
      |=> !receive_data)
      else $error("receive output released without mode change");
   a_wake_mode_kept: assert property (
      wake_o |-> mode_rdata_o == 2'h1 ##1 mode_rdata_o == 2'h1)
      else $error("mode field changed on wake");
   a_timeout_off: assert property (
      $rose(fail_o) |-> !bus_oe_o)
      else $error("failure set while driver still on");
endmodule // can_link_checker

// ---- verification/can_transceiver_mode_wake_control_test.sv ----
// Bench joining the controller end and transceiver end over the link
`timescale 1ns/1ps
`include "can_xcvr_regs.svh"
module can_transceiver_mode_wake_control_test;
   import can_xcvr_pkg::*;
   // Shortened counts keep the run brief
   localparam int unsigned EN = 8;
   localparam int unsigned TO = 64;
   localparam int unsigned WMIN = 4;
   localparam int unsigned WMAX = 12;
   localparam int unsigned BD = 4;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   power_mode_t pm = PM_NORMAL;
   logic [1:0] mode_wd = 2'h0;
   logic [1:0] mode_rd;
   logic [7:0] tx_data = 8'h00;
   logic mode_wr = 1'b0, normal_req = 1'b0, tx_valid = 1'b0;
   logic fail_clr = 1'b0, loop = 1'b0, bus_tb = 1'b0, txd2 = 1'b1;
   logic drv, oe, wake, fail, drv2, oe2, fail2, tx_ready, bus_dom, bias;
   int error_cnt = 0, checks = 0, cyc = 0, wakes = 0;
   can_link_if link1();
   can_link_if link2();
   // Second link lets the bench break the controller's enabling duty
   assign link2.transmit_data_input = txd2;
   assign bus_dom = loop ? (drv & oe) : bus_tb;
   can_ctrl_end #(.BIT_DIV(BD), .EN_CYC(EN)) u_can_ctrl_end (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .link(link1.ctrl),
      .normal_req_i(normal_req), .tx_valid_i(tx_valid),
      .tx_ready_o(tx_ready), .tx_data_i(tx_data), .tx_enabled_o(),
      .rx_bit_o(), .rx_valid_o());
   can_xcvr_dev #(.EN_CYC(EN), .TXD_TO_CYC(TO), .WAKE_MIN_CYC(WMIN),
      .WAKE_MAX_CYC(WMAX)) u_can_xcvr_dev (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .link(link1.dev),
      .power_mode_i(pm), .mode_wr_i(mode_wr), .mode_wdata_i(mode_wd),
      .mode_rdata_o(mode_rd), .bus_dom_i(bus_dom), .bus_drv_o(drv),
      .bus_oe_o(oe), .bus_bias_o(bias), .wake_o(wake), .fail_o(fail),
      .fail_clr_i(fail_clr));
   can_xcvr_dev #(.EN_CYC(EN), .TXD_TO_CYC(TO), .WAKE_MIN_CYC(WMIN),
      .WAKE_MAX_CYC(WMAX)) u_can_xcvr_dev_b (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .link(link2.dev),
      .power_mode_i(pm), .mode_wr_i(mode_wr), .mode_wdata_i(mode_wd),
      .mode_rdata_o(), .bus_dom_i(1'b0), .bus_drv_o(drv2),
      .bus_oe_o(oe2), .bus_bias_o(), .wake_o(), .fail_o(fail2),
      .fail_clr_i(fail_clr));
   can_link_checker u_can_link_checker (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .transmit_data_input(link1.transmit_data_input),
      .receive_data(link1.receive_data), .power_mode_i(pm),
      .mode_wr_i(mode_wr), .mode_wdata_i(mode_wd), .mode_rdata_o(mode_rd),
      .bus_drv_o(drv), .bus_oe_o(oe), .wake_o(wake), .fail_o(fail));

   task automatic stop_test();
      $display("mismatches %0d, comparisons %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic c, input string m);
      checks++;
      if (c !== 1'b1) begin
         error_cnt++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   // Ends just past the edge so that outputs have settled
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic wr_mode(input logic [1:0] m);
      @(posedge ref_clk_i);
      mode_wr <= 1'b1;
      mode_wd <= m;
      @(posedge ref_clk_i);
      mode_wr <= 1'b0;
      tick(3);
   endtask
   task automatic wake_pattern(input int a, input int b, input int c);
      bus_tb <= 1'b1;
      tick(a);
      bus_tb <= 1'b0;
      tick(b);
      bus_tb <= 1'b1;
      tick(c);
      bus_tb <= 1'b0;
      tick(20);
   endtask

   task automatic t_modes();
      logic act;
      chk(mode_rd === `MODE_FLD_OFF && oe === 1'b0, "reset state");
      for (int p = 0; p < 4; p++) begin
         pm <= power_mode_t'(p);
         act = (p < 2);
         wr_mode(`MODE_FLD_NORM);
         chk(mode_rd === (act ? `MODE_FLD_NORM : `MODE_FLD_OFF), "norm");
         wr_mode(`MODE_FLD_WAKE);
         chk(mode_rd === `MODE_FLD_WAKE, "wake mode write");
         wr_mode(`MODE_FLD_RXO);
         chk(mode_rd === (act ? `MODE_FLD_RXO : `MODE_FLD_WAKE), "rxo");
         wr_mode(`MODE_FLD_OFF);
         chk(mode_rd === `MODE_FLD_OFF, "off mode write");
      end
      pm <= PM_NORMAL;
   endtask
   task automatic t_normal();
      int n = 0;
      logic [7:0] exp_w = 8'h5A;
      loop <= 1'b1;
      txd2 <= 1'b0;
      @(posedge ref_clk_i);
      mode_wr <= 1'b1;
      mode_wd <= `MODE_FLD_NORM;
      normal_req <= 1'b1;
      tx_data <= 8'h5A;
      tx_valid <= 1'b1;
      @(posedge ref_clk_i);
      mode_wr <= 1'b0;
      normal_req <= 1'b0;
      fork
         begin
            #1;
            while (tx_ready === 1'b1 && n < 40) begin
               tick(1);
               n++;
               tx_data <= 8'h33;
            end
            tx_valid <= 1'b0;
         end
         begin
            for (int i = 0; i < 60 && link1.transmit_data_input !== 1'b0; i++)
               tick(1);
            tick(2);
            for (int i = 7; i >= 0; i--) begin
               chk(link1.transmit_data_input === exp_w[i], "bit order");
               tick(BD);
            end
         end
      join
      chk(n >= 16 && n <= 17, "fifo refused at depth");
      chk(oe === 1'b1, "driver enabled after delay");
      tick(700);
      chk(tx_ready === 1'b1 && link1.transmit_data_input === 1'b1, "drain");
      chk(oe2 === 1'b0, "low held through delay was sent");
   endtask
   task automatic t_timeout();
      txd2 <= 1'b1;
      tick(3);
      txd2 <= 1'b0;
      tick(2);
      chk(oe2 === 1'b1 && drv2 === 1'b1, "next dominant sent");
      tick(TO + 4);
      chk(oe2 === 1'b0 && fail2 === 1'b1, "time-out");
      txd2 <= 1'b1;
      tick(3);
      chk(oe2 === 1'b1 && fail2 === 1'b1, "driver back, flag kept");
      fail_clr <= 1'b1;
      tick(1);
      fail_clr <= 1'b0;
      tick(2);
      chk(fail2 === 1'b0, "failure flag clear");
   endtask
   task automatic t_rxo();
      loop <= 1'b0;
      wr_mode(`MODE_FLD_RXO);
      bus_tb <= 1'b1;
      tick(6);
      chk(link1.receive_data === 1'b0 && oe === 1'b0, "rxo dominant");
      bus_tb <= 1'b0;
      tick(6);
      chk(link1.receive_data === 1'b1, "rxo recessive");
      chk(bias === 1'b1, "bias in receive-only");
   endtask
   task automatic t_wake();
      pm <= PM_SLEEP;
      wr_mode(`MODE_FLD_OFF);
      wakes = 0;
      wake_pattern(8, 8, 8);
      chk(wakes == 0 && link1.receive_data === 1'b1, "wake in off");
      chk(bias === 1'b0 && oe === 1'b0, "off mode pins");
      wr_mode(`MODE_FLD_WAKE);
      wake_pattern(8, WMAX + 8, 8);
      chk(wakes == 0, "overlong phase woke");
      wake_pattern(WMIN, WMAX, WMIN);
      chk(wakes == 1 && link1.receive_data === 1'b0, "wake");
      chk(mode_rd === `MODE_FLD_WAKE, "mode after wake");
      wake_pattern(8, 8, 8);
      chk(wakes == 1, "woke again without re-arm");
      pm <= PM_STOP;
      tick(3);
      wake_pattern(8, 8, 8);
      chk(wakes == 2 && link1.receive_data === 1'b0, "re-arm by stop");
      pm <= PM_NORMAL;
      wr_mode(`MODE_FLD_NORM);
      chk(mode_rd === `MODE_FLD_NORM, "normal after wake");
      chk(link1.receive_data === 1'b1, "receive released");
      pm <= PM_FAILSAFE;
      tick(4);
      chk(mode_rd === `MODE_FLD_WAKE, "fail-safe mode");
   endtask

   initial begin
      forever #4 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i) begin
      cyc++;
      if (wake === 1'b1)
         wakes++;
      if (cyc == 8000) begin
         error_cnt++;
         stop_test();
      end
   end
   initial begin
      tick(5);
      rst_n_i <= 1'b1;
      tick(1);
      t_modes();
      t_normal();
      t_timeout();
      t_rxo();
      t_wake();
      stop_test();
   end
endmodule // can_transceiver_mode_wake_control_test
